// [rtl/rtm_pkg.sv]
package rtm_pkg;
  // =====================================================
  // timing
  localparam int CLK_PERIOD_NS        = 20;
  localparam int EE_BYTE_WRITE_NS     = 11_000_000;
  localparam int EE_BYTE_WRITE_CYCLES =
    (EE_BYTE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // =====================================================
  // address map
  localparam logic [15:0] EE_USER_BASE    = 16'hFF00;
  localparam logic [15:0] OTP_BASE        = 16'hFF80;
  localparam logic [15:0] SERIAL_ADDR     = 16'hFFF0;
  localparam logic [15:0] SERIAL_READ_LEN = 16'h0008;
  localparam int          EE_BYTES        = 20;
  localparam int          OTP_BLOCKS      = 5;
  localparam int          FRAM_BYTES_DEF  = 8192;
  // locks are nonvolatile; this is the factory state
  localparam logic [4:0]  LOCK_FACTORY    = 5'h00;
  // =====================================================
  // types
  typedef enum logic [1:0] {RTM_OP_READ, RTM_OP_WRITE, RTM_OP_INIT} rtm_op_e;
  typedef enum logic [1:0] {RTM_ST_OK, RTM_ST_BAD_ADDR, RTM_ST_LOCKED,
                            RTM_ST_BAD_OTP} rtm_status_e;
  typedef struct packed {
    rtm_op_e     op;
    logic [15:0] addr;
    logic [15:0] len;
    logic [7:0]  fill;
  } rtm_cmd_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rtm_byte_s;
endpackage

// [rtl/rtm_eeprom.sv]
`timescale 1ns/1ns
module rtm_eeprom #(
  parameter int WRITE_CYCLES = rtm_pkg::EE_BYTE_WRITE_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  input  wire logic       wr_en_in,
  input  wire logic [4:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [4:0] rd_idx_in,
  output logic      [7:0] rd_data_out,
  input  wire logic [4:0] lock_set_in,
  output logic      [4:0] lock_out,
  output logic            busy_out
);
  // =====================================================
  // storage
  logic [7:0]                           cells [rtm_pkg::EE_BYTES];
  // no reset: a reset must not undo a lock
  logic [4:0]                           lock = rtm_pkg::LOCK_FACTORY;
  logic [$clog2(WRITE_CYCLES + 1)-1:0] timer;

  wire  [2:0] wr_blk     = wr_idx_in[4:2];
  wire        idx_ok     = wr_idx_in < 5'(rtm_pkg::EE_BYTES);
  wire        wr_allowed = wr_en_in && idx_ok && !busy_out && !lock[wr_blk];
  wire  [7:0] wr_cell    = cells[wr_idx_in];

  assign rd_data_out = cells[rd_idx_in];
  assign lock_out    = lock;
  assign busy_out    = timer != '0;

  always_ff @(posedge clk_in) begin
    if (ce_in && wr_allowed) begin
      cells[wr_idx_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      lock <= lock | lock_set_in;
    end
  end

  // =====================================================
  // per-byte programming time
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer <= '0;
    end else if (ce_in) begin
      if (wr_allowed) begin
        timer <= ($clog2(WRITE_CYCLES + 1))'(WRITE_CYCLES);
      end else if (busy_out) begin
        timer <= timer - 1'b1;
      end
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in || !ce_in);

  chk_lock_never_clears: assert property (
    (lock & $past(lock)) == $past(lock)) else $error("lock bit cleared");
  chk_locked_cell_kept: assert property (
    wr_en_in && idx_ok && lock[wr_blk] |=> cells[$past(wr_idx_in)] == $past(wr_cell))
    else $error("locked byte changed");
  chk_write_pace: assert property (
    wr_allowed |=> busy_out && timer == WRITE_CYCLES) else $error("write time not started");
endmodule // rtm_eeprom

// [rtl/rtm_tag_memory.sv]
`timescale 1ns/1ns
module rtm_tag_memory #(
  parameter int          FRAM_BYTES      = rtm_pkg::FRAM_BYTES_DEF,
  parameter int          EE_WRITE_CYCLES = rtm_pkg::EE_BYTE_WRITE_CYCLES,
  parameter logic [31:0] SERIAL          = 32'h1234ABCD // arbitrary value
) (
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  input  wire logic                ce_in,
  input  wire logic                cmd_valid_in,
  input  wire rtm_pkg::rtm_cmd_s   cmd_in,
  input  wire logic                wr_valid_in,
  input  wire logic [7:0]          wr_data_in,
  output logic                     wr_ready_out,
  output rtm_pkg::rtm_byte_s       rd_out,
  output logic                     busy_out,
  output logic                     done_out,
  output rtm_pkg::rtm_status_e     status_out,
  output logic [4:0]               lock_out
);
  localparam int FRAM_MEM = (FRAM_BYTES == 0) ? 1 : FRAM_BYTES;
  localparam int AW       = (FRAM_MEM > 1) ? $clog2(FRAM_MEM) : 1;

  typedef enum logic [2:0] {S_IDLE, S_READ, S_WRITE, S_EE_WAIT, S_INIT} rtm_state_e;

  // =====================================================
  // helpers
  function automatic logic [4:0] blk_mask(input logic [2:0] first, input logic [2:0] last);
    logic [4:0] m;
    m = '0;
    for (int i = 0; i < rtm_pkg::OTP_BLOCKS; i++) begin
      m[i] = (3'(i) >= first) && (3'(i) <= last);
    end
    return m;
  endfunction

  function automatic logic [2:0] lock_count(input logic [4:0] l);
    logic [2:0] n;
    n = '0;
    for (int i = 0; i < rtm_pkg::OTP_BLOCKS; i++) begin
      n = n + 3'(l[i]);
    end
    return n;
  endfunction

  // =====================================================
  // state
  rtm_state_e        state;
  rtm_pkg::rtm_cmd_s cmd;
  logic [16:0]       cnt;
  logic              tgt_ee;
  logic              tgt_serial;
  logic              is_otp;
  logic [4:0]        otp_mask;
  logic [7:0]        fram [FRAM_MEM];
  logic [4:0]        ee_lock;
  logic              ee_busy;
  logic [7:0]        ee_rd;

  // =====================================================
  // command decode
  wire [16:0] end_addr   = {1'b0, cmd_in.addr} + {1'b0, cmd_in.len};
  wire        len_ok     = cmd_in.len != '0;
  wire        is_rd      = cmd_in.op == rtm_pkg::RTM_OP_READ;
  wire        is_wr      = cmd_in.op == rtm_pkg::RTM_OP_WRITE;
  wire        is_init    = cmd_in.op == rtm_pkg::RTM_OP_INIT;
  wire        in_serial  = cmd_in.addr == rtm_pkg::SERIAL_ADDR
                        && cmd_in.len == rtm_pkg::SERIAL_READ_LEN;
  wire        in_user    = cmd_in.addr >= rtm_pkg::EE_USER_BASE && end_addr
                        <= {1'b0, rtm_pkg::EE_USER_BASE} + 17'(rtm_pkg::EE_BYTES);
  wire        in_otp     = cmd_in.addr >= rtm_pkg::OTP_BASE && end_addr
                        <= {1'b0, rtm_pkg::OTP_BASE} + 17'(rtm_pkg::EE_BYTES);
  wire        otp_zone   = cmd_in.addr >= rtm_pkg::OTP_BASE
                        && cmd_in.addr < rtm_pkg::OTP_BASE + 16'(rtm_pkg::EE_BYTES);
  wire        has_fram   = FRAM_BYTES != 0;
  wire        in_fram    = has_fram && end_addr <= 17'(FRAM_BYTES)
                        && end_addr <= {1'b0, rtm_pkg::EE_USER_BASE};
  // user and lock ranges share the low five address bits
  wire [2:0]  first_blk  = cmd_in.addr[4:2];
  wire [4:0]  last_off   = cmd_in.addr[4:0] + cmd_in.len[4:0] - 5'h01;
  wire [4:0]  span       = blk_mask(first_blk, last_off[4:2]);
  wire        user_lockd = |(span & ee_lock);
  wire        otp_ok     = in_otp && cmd_in.addr[1:0] == 2'h0 && cmd_in.len[1:0] == 2'h0
                        && first_blk == lock_count(ee_lock);
  wire        rd_ok      = len_ok && (in_serial || in_user || in_otp || in_fram);
  wire rtm_pkg::rtm_status_e wr_status =
      !len_ok   ? rtm_pkg::RTM_ST_BAD_ADDR :
      otp_zone  ? (otp_ok ? rtm_pkg::RTM_ST_OK : rtm_pkg::RTM_ST_BAD_OTP) :
      in_user   ? (user_lockd ? rtm_pkg::RTM_ST_LOCKED : rtm_pkg::RTM_ST_OK) :
      in_fram   ? rtm_pkg::RTM_ST_OK : rtm_pkg::RTM_ST_BAD_ADDR;
  wire rtm_pkg::rtm_status_e cmd_status =
      is_rd   ? (rd_ok ? rtm_pkg::RTM_ST_OK : rtm_pkg::RTM_ST_BAD_ADDR) :
      is_wr   ? wr_status :
      is_init ? (has_fram ? rtm_pkg::RTM_ST_OK : rtm_pkg::RTM_ST_BAD_ADDR) :
                rtm_pkg::RTM_ST_BAD_ADDR;
  wire rtm_state_e start_state = is_rd ? S_READ : is_wr ? S_WRITE : S_INIT;
  wire        accept_cmd = state == S_IDLE && cmd_valid_in;

  // =====================================================
  // datapath
  wire [16:0] cnt_next   = cnt + 17'h00001;
  wire [15:0] cur_addr   = cmd.addr + cnt[15:0];
  wire        rd_last    = cnt_next == {1'b0, cmd.len};
  wire        cnt_done   = cnt == {1'b0, cmd.len};
  wire        init_last  = cnt_next == 17'(FRAM_MEM);
  wire        wr_take    = state == S_WRITE && wr_valid_in;
  wire        ee_wr_en   = wr_take && tgt_ee;
  wire        fram_we    = (wr_take && !tgt_ee) || state == S_INIT;
  wire [AW-1:0] fram_idx = (state == S_INIT) ? cnt[AW-1:0] : cur_addr[AW-1:0];
  wire [7:0]  fram_wd    = (state == S_INIT) ? cmd.fill : wr_data_in;
  wire        ee_free    = state == S_EE_WAIT && !ee_busy;
  wire [4:0]  lock_set   = (ee_free && cnt_done && is_otp) ? otp_mask : 5'h00;
  // upper four bytes of the 8-byte value are zero, serial follows MSB first
  wire [7:0]  serial_b   = !cnt[2] ? 8'h00 : SERIAL[8 * (3 - int'(cnt[1:0])) +: 8];
  wire [7:0]  rd_byte    = tgt_serial ? serial_b : tgt_ee ? ee_rd : fram[cur_addr[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (ce_in && !reset_in && fram_we) begin
      fram[fram_idx] <= fram_wd;
    end
  end

  // slow programming stalls the reader through wr_ready_out
  rtm_eeprom #(
    .WRITE_CYCLES (EE_WRITE_CYCLES)
  ) u_eeprom (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .ce_in       (ce_in),
    .wr_en_in    (ee_wr_en),
    .wr_idx_in   (cur_addr[4:0]),
    .wr_data_in  (wr_data_in),
    .rd_idx_in   (cur_addr[4:0]),
    .rd_data_out (ee_rd),
    .lock_set_in (lock_set),
    .lock_out    (ee_lock),
    .busy_out    (ee_busy)
  );

  // =====================================================
  // sequencer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state        <= S_IDLE;
      cmd          <= '0;
      cnt          <= '0;
      tgt_ee       <= 1'b0;
      tgt_serial   <= 1'b0;
      is_otp       <= 1'b0;
      otp_mask     <= '0;
      wr_ready_out <= 1'b0;
      rd_out       <= '0;
      busy_out     <= 1'b0;
      done_out     <= 1'b0;
      status_out   <= rtm_pkg::RTM_ST_OK;
      lock_out     <= '0;
    end else if (ce_in) begin
      done_out     <= 1'b0;
      rd_out.valid <= 1'b0;
      lock_out     <= ee_lock | lock_set;
      unique case (state)
        S_IDLE: begin
          if (accept_cmd) begin
            cmd        <= cmd_in;
            cnt        <= '0;
            tgt_ee     <= in_user || in_otp;
            tgt_serial <= in_serial && is_rd;
            is_otp     <= otp_zone;
            otp_mask   <= blk_mask(first_blk, 3'(first_blk + 3'(cmd_in.len[4:2]) - 3'h1));
            status_out <= cmd_status;
            if (cmd_status != rtm_pkg::RTM_ST_OK) begin
              done_out <= 1'b1;
            end else begin
              busy_out     <= 1'b1;
              state        <= start_state;
              wr_ready_out <= is_wr;
            end
          end
        end
        S_READ: begin
          rd_out.valid <= 1'b1;
          rd_out.data  <= rd_byte;
          cnt          <= cnt_next;
          if (rd_last) begin
            state    <= S_IDLE;
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
        S_WRITE: begin
          if (wr_valid_in) begin
            cnt <= cnt_next;
            if (tgt_ee) begin
              state        <= S_EE_WAIT;
              wr_ready_out <= 1'b0;
            end else if (rd_last) begin
              state        <= S_IDLE;
              wr_ready_out <= 1'b0;
              busy_out     <= 1'b0;
              done_out     <= 1'b1;
            end
          end
        end
        S_EE_WAIT: begin
          if (ee_free) begin
            if (cnt_done) begin
              state    <= S_IDLE;
              busy_out <= 1'b0;
              done_out <= 1'b1;
            end else begin
              state        <= S_WRITE;
              wr_ready_out <= 1'b1;
            end
          end
        end
        S_INIT: begin
          cnt <= cnt_next;
          if (init_last) begin
            state    <= S_IDLE;
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
      endcase
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in || !ce_in);

  chk_serial_zero_top: assert property (
    state == S_READ && tgt_serial && cnt < 17'h4 |=> rd_out.valid && rd_out.data == 8'h00)
    else $error("serial upper byte not zero");
  chk_serial_first_byte: assert property (
    state == S_READ && tgt_serial && cnt == 17'h4 |=> rd_out.data == SERIAL[31:24])
    else $error("serial byte wrong");
  chk_serial_no_write: assert property (
    accept_cmd && is_wr && cmd_in.addr == rtm_pkg::SERIAL_ADDR
    |=> done_out && status_out == rtm_pkg::RTM_ST_BAD_ADDR) else $error("serial written");
  chk_user_locked_refuse: assert property (
    accept_cmd && is_wr && !otp_zone && in_user && len_ok && user_lockd
    |=> done_out && status_out == rtm_pkg::RTM_ST_LOCKED && state == S_IDLE)
    else $error("locked write accepted");
  chk_otp_order_refuse: assert property (
    accept_cmd && is_wr && otp_zone && first_blk != lock_count(ee_lock)
    |=> done_out && status_out == rtm_pkg::RTM_ST_BAD_OTP) else $error("out-of-order lock taken");
  chk_otp_locks_set: assert property (
    lock_set != 5'h00 |=> (ee_lock & $past(lock_set)) == $past(lock_set) && done_out)
    else $error("lock not set");
  chk_init_fram_only: assert property (
    state == S_INIT |-> fram_we && !ee_wr_en) else $error("init touched user area");
  chk_ee_stall: assert property (
    ee_wr_en |=> state == S_EE_WAIT && !wr_ready_out ##1 ee_busy)
    else $error("no stall on slow write");
  chk_no_fram_init: assert property (
    accept_cmd && is_init && !has_fram |=> done_out && status_out == rtm_pkg::RTM_ST_BAD_ADDR)
    else $error("init on tag without fram");

  cov_serial_read: cover property (state == S_READ && tgt_serial && rd_last);
  cov_otp_lock:    cover property (lock_set != 5'h00);
  cov_init_done:   cover property (state == S_INIT && init_last);
  cov_user_write:  cover property (ee_free && cnt_done && !is_otp);
endmodule // rtm_tag_memory

// [verification/rtm_reader_model.sv]
`timescale 1ns/1ns
// =====================================================
// reader side: one command at a time, each byte held until taken
module rtm_reader_model (
  input  wire logic                 clk_in,
  output logic                      cmd_valid_out,
  output rtm_pkg::rtm_cmd_s         cmd_out,
  output logic                      wr_valid_out,
  output logic [7:0]                wr_data_out,
  input  wire logic                 wr_ready_in,
  input  wire rtm_pkg::rtm_byte_s   rd_in,
  input  wire logic                 done_in,
  input  wire rtm_pkg::rtm_status_e status_in
);
  logic [7:0] wr_q [$];
  logic [7:0] rd_q [$];
  // a run that ends without done must not look finished
  logic       done_seen = 1'b0;
  int         cycles    = 0;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    wr_valid_out = 1'b0;
    wr_data_out = 8'h00;
  end

  // plain reader variant, lock-block writes allowed
  task automatic run(input rtm_pkg::rtm_op_e op, input logic [15:0] addr,
                     input logic [15:0] len, output rtm_pkg::rtm_status_e st);
    int k;
    k = 0;
    st = rtm_pkg::RTM_ST_OK;
    done_seen = 1'b0;
    cycles = 0;
    rd_q.delete();
    cmd_valid_out <= 1'b1;
    cmd_out <= '{op: op, addr: addr, len: len, fill: 8'hC3};
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    for (int t = 0; t < 10000; t++) begin
      wr_valid_out <= (op == rtm_pkg::RTM_OP_WRITE) && (k < wr_q.size());
      if (k < wr_q.size()) begin
        wr_data_out <= wr_q[k];
      end
      @(posedge clk_in);
      cycles++;
      if (wr_valid_out && wr_ready_in === 1'b1) begin
        k++;
      end
      if (rd_in.valid === 1'b1) begin
        rd_q.push_back(rd_in.data);
      end
      if (done_in === 1'b1) begin
        st = status_in;
        done_seen = 1'b1;
        break;
      end
    end
    // released data line must not keep looking valid
    wr_valid_out <= 1'b0;
    wr_data_out <= ~wr_data_out;
    wr_q.delete();
  endtask
endmodule // rtm_reader_model

// [verification/tb_top.sv]
`timescale 1ns/1ns
// =====================================================
// bench
module tb_top;
  localparam logic [31:0] SER  = 32'h5A3C0F96; // arbitrary value
  localparam int          FRAM = 8192;
  // short programming time keeps the run small
  localparam int          EE_CYC = 3;
  logic                 clk_in;
  logic                 reset_in;
  logic                 ce_in;
  logic                 cmd_valid;
  rtm_pkg::rtm_cmd_s    cmd;
  logic                 wr_valid;
  logic [7:0]           wr_data;
  logic                 wr_ready;
  rtm_pkg::rtm_byte_s   rd;
  logic                 busy;
  logic                 done;
  rtm_pkg::rtm_status_e status;
  logic [4:0]           lock;
  int                   num_errors = 0;
  int                   compares = 0;

  rtm_tag_memory #(.FRAM_BYTES(FRAM), .EE_WRITE_CYCLES(EE_CYC), .SERIAL(SER)) rtm_tag_memory_i (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .wr_valid_in(wr_valid), .wr_data_in(wr_data), .wr_ready_out(wr_ready),
    .rd_out(rd), .busy_out(busy), .done_out(done), .status_out(status), .lock_out(lock));

  rtm_reader_model rtm_reader_model_i (
    .clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd), .wr_valid_out(wr_valid),
    .wr_data_out(wr_data), .wr_ready_in(wr_ready), .rd_in(rd), .done_in(done),
    .status_in(status));

  // =====================================================
  // compare tasks
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_lock(input string what, input logic [4:0] exp, input logic [4:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_st(input rtm_pkg::rtm_status_e exp, input rtm_pkg::rtm_status_e got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR status expected %0d seen %0d", exp, got);
    end
  endtask

  task automatic go(input rtm_pkg::rtm_op_e op, input logic [15:0] a, input logic [15:0] n,
                    input rtm_pkg::rtm_status_e exp);
    rtm_pkg::rtm_status_e st;
    rtm_reader_model_i.run(op, a, n, st);
    chk_st(exp, st);
    chk_flag("done seen", 1'b1, rtm_reader_model_i.done_seen);
    chk_flag("busy after done", 1'b0, busy);
  endtask

  task automatic rd_chk(input logic [7:0] exp [$]);
    chk_byte("read count", 8'(exp.size()), 8'(rtm_reader_model_i.rd_q.size()));
    foreach (exp[i]) begin
      chk_byte("read byte", exp[i], rtm_reader_model_i.rd_q[i]);
    end
  endtask

  // =====================================================
  // scenarios
  task automatic t_serial;
    go(rtm_pkg::RTM_OP_READ, 16'hFFF0, 16'h0008, rtm_pkg::RTM_ST_OK);
    rd_chk('{8'h00, 8'h00, 8'h00, 8'h00, SER[31:24], SER[23:16], SER[15:8], SER[7:0]});
    go(rtm_pkg::RTM_OP_READ, 16'hFFF0, 16'h0004, rtm_pkg::RTM_ST_BAD_ADDR);
    rtm_reader_model_i.wr_q = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
    go(rtm_pkg::RTM_OP_WRITE, 16'hFFF0, 16'h0008, rtm_pkg::RTM_ST_BAD_ADDR);
    go(rtm_pkg::RTM_OP_READ, 16'hFFF0, 16'h0008, rtm_pkg::RTM_ST_OK);
    rd_chk('{8'h00, 8'h00, 8'h00, 8'h00, SER[31:24], SER[23:16], SER[15:8], SER[7:0]});
    $display("test serial done");
  endtask

  task automatic t_user;
    rtm_reader_model_i.wr_q = '{8'h11, 8'h22, 8'h33, 8'h44};
    go(rtm_pkg::RTM_OP_WRITE, 16'hFF10, 16'h0004, rtm_pkg::RTM_ST_OK);
    chk_flag("ee write paced", 1'b1, rtm_reader_model_i.cycles >= 4 * EE_CYC);
    go(rtm_pkg::RTM_OP_READ, 16'hFF90, 16'h0004, rtm_pkg::RTM_ST_OK);
    rd_chk('{8'h11, 8'h22, 8'h33, 8'h44});
    go(rtm_pkg::RTM_OP_READ, 16'hFF11, 16'h0003, rtm_pkg::RTM_ST_OK);
    rd_chk('{8'h22, 8'h33, 8'h44});
    go(rtm_pkg::RTM_OP_READ, 16'hFF13, 16'h0002, rtm_pkg::RTM_ST_BAD_ADDR);
    $display("test user done");
  endtask

  task automatic t_fram;
    rtm_reader_model_i.wr_q = '{8'hA1, 8'hB2};
    go(rtm_pkg::RTM_OP_WRITE, 16'h1FFE, 16'h0002, rtm_pkg::RTM_ST_OK);
    chk_flag("fram write fast", 1'b1, rtm_reader_model_i.cycles < 2 * EE_CYC);
    go(rtm_pkg::RTM_OP_READ, 16'h1FFE, 16'h0002, rtm_pkg::RTM_ST_OK);
    rd_chk('{8'hA1, 8'hB2});
    go(rtm_pkg::RTM_OP_READ, 16'h2000, 16'h0001, rtm_pkg::RTM_ST_BAD_ADDR);
    go(rtm_pkg::RTM_OP_INIT, 16'h0000, 16'h0000, rtm_pkg::RTM_ST_OK);
    go(rtm_pkg::RTM_OP_READ, 16'h1FFE, 16'h0002, rtm_pkg::RTM_ST_OK);
    rd_chk('{8'hC3, 8'hC3});
    go(rtm_pkg::RTM_OP_READ, 16'hFF10, 16'h0004, rtm_pkg::RTM_ST_OK);
    rd_chk('{8'h11, 8'h22, 8'h33, 8'h44});
    $display("test fram done");
  endtask

  task automatic t_otp;
    rtm_reader_model_i.wr_q = '{8'h0A, 8'h0B, 8'h0C, 8'h0D};
    go(rtm_pkg::RTM_OP_WRITE, 16'hFF84, 16'h0004, rtm_pkg::RTM_ST_BAD_OTP);
    rtm_reader_model_i.wr_q = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
    go(rtm_pkg::RTM_OP_WRITE, 16'hFF80, 16'h0006, rtm_pkg::RTM_ST_BAD_OTP);
    chk_lock("lock", 5'h00, lock);
    rtm_reader_model_i.wr_q = '{8'hD0, 8'hD1, 8'hD2, 8'hD3};
    go(rtm_pkg::RTM_OP_WRITE, 16'hFF80, 16'h0004, rtm_pkg::RTM_ST_OK);
    chk_lock("lock", 5'h01, lock);
    rtm_reader_model_i.wr_q = '{8'hEE};
    go(rtm_pkg::RTM_OP_WRITE, 16'hFF01, 16'h0001, rtm_pkg::RTM_ST_LOCKED);
    rtm_reader_model_i.wr_q = '{8'hEE, 8'hEE, 8'hEE, 8'hEE};
    go(rtm_pkg::RTM_OP_WRITE, 16'hFF80, 16'h0004, rtm_pkg::RTM_ST_BAD_OTP);
    go(rtm_pkg::RTM_OP_READ, 16'hFF00, 16'h0004, rtm_pkg::RTM_ST_OK);
    rd_chk('{8'hD0, 8'hD1, 8'hD2, 8'hD3});
    rtm_reader_model_i.wr_q = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
    go(rtm_pkg::RTM_OP_WRITE, 16'hFF84, 16'h0008, rtm_pkg::RTM_ST_OK);
    chk_lock("lock", 5'h07, lock);
    // locks are nonvolatile, so a reset in mid-run must keep them
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk_lock("lock after reset", 5'h07, lock);
    $display("test otp done");
  endtask

  // =====================================================
  // run control
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  initial begin
    repeat (30000) @(posedge clk_in);
    num_errors++;
    wrap_up();
  end

  initial begin
    reset_in = 1'b1;
    ce_in = 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk_lock("lock after reset", 5'h00, lock);
    t_serial();
    t_user();
    t_fram();
    t_otp();
    wrap_up();
  end
endmodule // tb_top
